// file: eeprom_bus_defs.svh
// Constants for the two-wire memory front end and its controller.
// Assumes a 250 MHz system clock on both ends.
`ifndef EEPROM_BUS_DEFS_SVH
`define EEPROM_BUS_DEFS_SVH

`define CLK_PERIOD_NS     4
`define WORD_BITS         8
`define ACK_BIT_IDX       4'h8
`define LAST_DATA_IDX     4'h7
`define PREFIX_VALUE      5'h14
`define RW_BIT_POS        0
`define SEL_LO_POS        1
`define SEL_HI_POS        2
`define PREFIX_LSB        3
`define RECOVER_CLOCKS    4'h9
// Write cycle bound in ms per grade
`define WR_TIME_LOWV_MS   20
`define WR_TIME_STD_MS    10
`define WR_TIME_IMPR_MS   5
`define WR_CYCLES(ms)     ((ms) * 1000000 / `CLK_PERIOD_NS)
// Half period of the bus clock made by the controller, in system cycles
`define SCL_HALF_DIV      8'h0A

`endif

// file: eeprom_bus_pkg.sv
// Types shared by both ends of the two-wire memory link.
// Assumes the constants header is compiled alongside.
package eeprom_bus_pkg;
	typedef enum logic [1:0] {GRADE_LOWV, GRADE_STD, GRADE_IMPR} grade_t;
	typedef logic [7:0] word_t;
endpackage

// file: fifo_buf.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
module fifo_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	// Handshakes
	assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage
	always_ff @(posedge ref_clk_i) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

	// Pointers and fill level
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push)
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// file: eeprom_bus_if.sv
// Two-wire bus between memory front end and controller.
// Wire levels are resolved here from the open-drain enables.
interface eeprom_bus_if;
	logic scl_oe;   // Controller pulls clock low
	logic sda_ctl_oe;
	logic sda_mem_oe;
	logic scl;
	logic sda;

	// Pull-up wins unless someone pulls low
	assign scl = ~scl_oe;
	assign sda = ~(sda_ctl_oe | sda_mem_oe);

	modport mem (input scl, input sda, output sda_mem_oe);
	modport ctl (input scl, input sda, output scl_oe, output sda_ctl_oe);
endinterface

// file: eeprom_front_end.sv
// Memory side of the two-wire link: conditions, words, ack, addressing.
// Assumes bus pins are asynchronous to ref_clk_i and pulled up.
`include "eeprom_bus_defs.svh"

// Behaviour
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - stop after a read enters standby
// - data changes only while SCL is low
// - every item moves as 8-bit word
// - memory pulls SDA low on ninth clock
// - standby at reset and after stop completion
// - controller recovers with nine clocks then start
// - device address word follows every start
// - five top bits match fixed prefix
// - select bits compare with strapped inputs
// - unconnected select input reads as low
// - eighth bit one reads, zero writes
// - ack on match, else standby till start
// - write-protect high blocks array writes
// - write cycle bounded by grade time
// - sample on rise, change after fall
// - only pull SDA low or release
// - ignore bus during write cycle
module eeprom_front_end
	import eeprom_bus_pkg::*;
#(
	parameter logic [4:0] PREFIX   = `PREFIX_VALUE,
	parameter eeprom_bus_pkg::grade_t GRADE = GRADE_STD,
	parameter int         WR_LOWV  = `WR_CYCLES(`WR_TIME_LOWV_MS),
	parameter int         WR_STD   = `WR_CYCLES(`WR_TIME_STD_MS),
	parameter int         WR_IMPR  = `WR_CYCLES(`WR_TIME_IMPR_MS)
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	eeprom_bus_if.mem                 bus,
	input  wire logic                 select_input_high_i,
	input  wire logic                 select_input_low_i,
	input  wire logic                 write_protect_i,
	input  wire eeprom_bus_pkg::word_t tx_data_i,
	input  wire logic                 tx_valid_i,
	output logic                      tx_ready_o,
	output eeprom_bus_pkg::word_t     rx_data_o,
	output logic                      rx_valid_o,
	input  wire logic                 rx_ready_i,
	output logic                      selected_o,
	output logic                      read_mode_o,
	output logic                      standby_o,
	output logic                      write_busy_o
);
	import eeprom_bus_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TX_ACK, ST_WRITE} fe_state_t;

	localparam int WR_CYC = (GRADE == GRADE_LOWV) ? WR_LOWV : (GRADE == GRADE_IMPR) ? WR_IMPR : WR_STD;

	// ==========================================================
	// Pin synchronisers
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       scl_d_r;
	logic       sda_d_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
			scl_d_r    <= scl_sync_r[1];
			sda_d_r    <= sda_sync_r[1];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s     = scl_sync_r[1];
	assign sda_s     = sda_sync_r[1];
	assign scl_rise  = scl_s && !scl_d_r;
	assign scl_fall  = !scl_s && scl_d_r;
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;

	// ==========================================================
	// Outgoing words pass the FIFO before the shifter
	word_t tx_word;
	logic  tx_have;
	logic  tx_take;
	fifo_buf #(.WIDTH(`WORD_BITS), .DEPTH(8)) u_tx_fifo (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.in_data_i  (tx_data_i),
		.in_valid_i (tx_valid_i),
		.in_ready_o (tx_ready_o),
		.out_data_o (tx_word),
		.out_valid_o(tx_have),
		.out_ready_i(tx_take)
	);

	// ==========================================================
	// Protocol state
	fe_state_t   state_r;
	logic [3:0]  bit_cnt_r;
	word_t       shift_r;
	logic        addr_phase_r;
	logic        rd_r;
	logic        wrote_r;
	logic        nack_r;
	logic [31:0] wr_cnt_r;
	logic        sda_oe_r;
	logic        rx_valid_r;
	word_t       rx_data_r;
	logic        addr_match;

	// external pulls make a floating select read low
	assign addr_match = (shift_r[7:`PREFIX_LSB] == PREFIX)
		&& (shift_r[`SEL_HI_POS] == select_input_high_i)
		&& (shift_r[`SEL_LO_POS] == select_input_low_i);
	// Pop exactly when a word is loaded into the shifter
	assign tx_take = scl_fall && tx_have && !start_det && !stop_det
		&& (((state_r == ST_ACK) && rd_r) || ((state_r == ST_TX_ACK) && !nack_r));

	// Main sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_r      <= ST_IDLE;
			bit_cnt_r    <= 4'h0;
			shift_r      <= 8'h00;
			addr_phase_r <= 1'b0;
			rd_r         <= 1'b0;
			wrote_r      <= 1'b0;
			nack_r       <= 1'b0;
			wr_cnt_r     <= 32'h0;
			sda_oe_r     <= 1'b0;
		end else if (state_r == ST_WRITE) begin
			sda_oe_r <= 1'b0;
			if (wr_cnt_r >= 32'(WR_CYC - 1))
				state_r <= ST_IDLE;
			else
				wr_cnt_r <= wr_cnt_r + 32'h1;
		end else if (start_det) begin
			state_r      <= ST_ADDR;
			bit_cnt_r    <= 4'h0;
			addr_phase_r <= 1'b1;
			wrote_r      <= 1'b0;
			sda_oe_r     <= 1'b0;
		end else if (stop_det) begin
			sda_oe_r <= 1'b0;
			// stop after a write without write protect runs the write cycle first
			if (wrote_r && !rd_r && !write_protect_i) begin
				state_r  <= ST_WRITE;
				wr_cnt_r <= 32'h0;
			end else
				state_r <= ST_IDLE;
			wrote_r <= 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_RX: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_s};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == `ACK_BIT_IDX) begin
						bit_cnt_r <= 4'h0;
						if (addr_phase_r) begin
							if (addr_match) begin
								sda_oe_r <= 1'b1;
								rd_r     <= shift_r[`RW_BIT_POS];
								state_r  <= ST_ACK;
							end else
								state_r <= ST_IDLE;
							addr_phase_r <= 1'b0;
						end else begin
							sda_oe_r <= 1'b1;
							wrote_r  <= 1'b1;
							state_r  <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe_r <= 1'b0;
						if (rd_r) begin
							state_r  <= ST_TX;
							shift_r  <= tx_have ? tx_word : 8'hFF;
							sda_oe_r <= tx_have ? !tx_word[7] : 1'b0;
							bit_cnt_r <= 4'h1;
						end else
							state_r <= ST_RX;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_r == `LAST_DATA_IDX + 4'h1) begin
							sda_oe_r  <= 1'b0;
							state_r   <= ST_TX_ACK;
						end else begin
							sda_oe_r  <= !shift_r[3'(`LAST_DATA_IDX - bit_cnt_r)];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				ST_TX_ACK: begin
					// Controller ack continues; no ack returns to idle
					if (scl_rise)
						nack_r <= sda_s;
					else if (scl_fall) begin
						if (nack_r)
							state_r <= ST_IDLE;
						else begin
							state_r   <= ST_TX;
							shift_r   <= tx_have ? tx_word : 8'hFF;
							sda_oe_r  <= tx_have ? !tx_word[7] : 1'b0;
							bit_cnt_r <= 4'h1;
						end
					end
				end
				default: sda_oe_r <= 1'b0;
			endcase
		end
	end

	// Received data words, blocked under write protect
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			rx_valid_r <= 1'b0;
			rx_data_r  <= 8'h00;
		end else if (state_r == ST_RX && scl_fall && bit_cnt_r == `ACK_BIT_IDX
			&& !addr_phase_r && !write_protect_i) begin
			rx_valid_r <= 1'b1;
			rx_data_r  <= shift_r;
		end else if (rx_ready_i)
			rx_valid_r <= 1'b0;
	end

	// Status outputs, all registered
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			selected_o   <= 1'b0;
			read_mode_o  <= 1'b0;
			standby_o    <= 1'b1;
			write_busy_o <= 1'b0;
		end else begin
			selected_o   <= (state_r != ST_IDLE) && (state_r != ST_ADDR) && (state_r != ST_WRITE);
			read_mode_o  <= rd_r;
			standby_o    <= (state_r == ST_IDLE);
			write_busy_o <= (state_r == ST_WRITE);
		end
	end

	assign bus.sda_mem_oe = sda_oe_r;
	assign rx_data_o      = rx_data_r;
	assign rx_valid_o     = rx_valid_r;
endmodule

// file: eeprom_controller.sv
// Controller side of the two-wire link: makes clock, start, stop, words.
// Assumes the memory end shares the bus interface and system clock rate.
`include "eeprom_bus_defs.svh"

module eeprom_controller
	import eeprom_bus_pkg::*;
(
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	eeprom_bus_if.ctl                  bus,
	input  wire logic                  cmd_valid_i,
	input  wire logic                  cmd_start_i,
	input  wire logic                  cmd_stop_i,
	input  wire logic                  cmd_read_i,
	input  wire logic                  cmd_ack_i,
	input  wire logic                  cmd_recover_i,
	input  wire eeprom_bus_pkg::word_t cmd_data_i,
	output logic                       cmd_ready_o,
	output eeprom_bus_pkg::word_t      rsp_data_o,
	output logic                       rsp_ack_o,
	output logic                       rsp_valid_o
);
	import eeprom_bus_pkg::*;

	typedef enum logic [2:0] {C_IDLE, C_START, C_BITS, C_STOP, C_RECOVER} ctl_state_t;

	// Clock divider enable
	logic [7:0] div_r;
	logic       tick;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			div_r <= 8'h00;
		else
			div_r <= (div_r == `SCL_HALF_DIV - 8'h1) ? 8'h00 : div_r + 8'h1;
	end
	assign tick = (div_r == `SCL_HALF_DIV - 8'h1);

	// Data line sampling
	logic [1:0] sda_sync_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i)
			sda_sync_r <= 2'h3;
		else
			sda_sync_r <= {sda_sync_r[0], bus.sda};
	end

	// ==========================================================
	// Sequencer: each bit is two ticks, low then high
	ctl_state_t state_r;
	logic       scl_low_r;
	logic       sda_low_r;
	logic       phase_r;
	logic [3:0] bit_r;
	logic [8:0] sh_r;
	logic       rd_r;
	logic       stop_r;
	word_t      rsp_r;
	logic       ack_r;
	logic       rsp_valid_r;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_r     <= C_IDLE;
			scl_low_r   <= 1'b0;
			sda_low_r   <= 1'b0;
			phase_r     <= 1'b0;
			bit_r       <= 4'h0;
			sh_r        <= 9'h1FF;
			rd_r        <= 1'b0;
			stop_r      <= 1'b0;
			rsp_r       <= 8'h00;
			ack_r       <= 1'b0;
			rsp_valid_r <= 1'b0;
		end else begin
			rsp_valid_r <= 1'b0;
			case (state_r)
				C_IDLE: begin
					if (cmd_valid_i && tick) begin
						rd_r   <= cmd_read_i;
						stop_r <= cmd_stop_i;
						// Read shifts out ones; ack slot carries own answer
						sh_r   <= cmd_read_i ? {8'hFF, !cmd_ack_i} : {cmd_data_i, 1'b1};
						bit_r  <= 4'h0;
						phase_r <= 1'b0;
						if (cmd_recover_i)
							state_r <= C_RECOVER;
						else if (cmd_start_i)
							state_r <= C_START;
						else
							state_r <= C_BITS;
					end
				end
				C_START: if (tick) begin
					// clock low, release data, raise clock, then pull data low
					bit_r <= bit_r + 4'h1;
					if (bit_r == 4'h0) begin
						scl_low_r <= 1'b1;
						sda_low_r <= 1'b0;
					end else if (bit_r == 4'h1)
						scl_low_r <= 1'b0;
					else begin
						sda_low_r <= 1'b1;
						bit_r     <= 4'h0;
						phase_r   <= 1'b0;
						state_r   <= C_BITS;
					end
				end
				C_BITS: if (tick) begin
					phase_r <= !phase_r;
					if (!phase_r) begin
						scl_low_r <= 1'b1;
						sda_low_r <= !sh_r[8];
					end else begin
						scl_low_r <= 1'b0;
						sh_r      <= {sh_r[7:0], sda_sync_r[1]};
						bit_r     <= bit_r + 4'h1;
						if (bit_r == `ACK_BIT_IDX) begin
							bit_r       <= 4'h0;
							rsp_r       <= sh_r[7:0];
							ack_r       <= !sda_sync_r[1];
							rsp_valid_r <= 1'b1;
							state_r     <= stop_r ? C_STOP : C_IDLE;
						end
					end
				end
				C_STOP: if (tick) begin
					// pull data low under low clock, raise clock, release data
					bit_r <= bit_r + 4'h1;
					if (bit_r == 4'h0) begin
						scl_low_r <= 1'b1;
						sda_low_r <= 1'b1;
					end else if (bit_r == 4'h1)
						scl_low_r <= 1'b0;
					else begin
						sda_low_r <= 1'b0;
						bit_r     <= 4'h0;
						stop_r    <= 1'b0;
						state_r   <= C_IDLE;
					end
				end
				C_RECOVER: if (tick) begin
					// up to nine clocks until data reads high
					phase_r   <= !phase_r;
					sda_low_r <= 1'b0;
					if (!phase_r)
						scl_low_r <= 1'b1;
					else begin
						scl_low_r <= 1'b0;
						bit_r     <= bit_r + 4'h1;
						if (sda_sync_r[1] || bit_r == `RECOVER_CLOCKS - 4'h1) begin
							bit_r   <= 4'h0;
							state_r <= C_START;
						end
					end
				end
				default: state_r <= C_IDLE;
			endcase
		end
	end

	assign bus.scl_oe     = scl_low_r;
	assign bus.sda_ctl_oe = sda_low_r;
	assign cmd_ready_o    = (state_r == C_IDLE) && tick;
	assign rsp_data_o     = rsp_r;
	assign rsp_ack_o      = ack_r;
	assign rsp_valid_o    = rsp_valid_r;
endmodule

// file: eeprom_bus_assertions.sv
// Concurrent checks on the two-wire link between the memory end and the controller end.
// Assumes the link signals are sampled on the shared system clock, reset synchronous active low.
module eeprom_bus_assertions #(
	parameter logic [4:0] PREFIX = 5'h14
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic scl_oe,
	input  wire logic sda_ctl_oe,
	input  wire logic sda_mem_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_r;
	logic       sda_r;
	logic       first_r;
	logic       rd_r;
	logic       quiet_r;
	logic [3:0] cnt_r;
	logic [7:0] addr_r;
	logic       start;
	logic       stop;
	logic       rise;
	logic       high;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// ==========
	// Link event decode
	assign start = scl & scl_r & sda_r & ~sda;
	assign stop  = scl & scl_r & ~sda_r & sda;
	assign rise  = scl & ~scl_r;
	assign high  = scl & scl_r;

	// Previous wire levels
	always_ff @(posedge ref_clk_i) begin
		scl_r <= scl;
		sda_r <= sda;
	end

	// Bit position within the current word
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || start || stop) begin
			cnt_r <= 4'h0;
		end else if (rise) begin
			cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
		end
	end

	// Address word capture and direction
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || start) begin
			first_r <= 1'b1;
			rd_r    <= 1'b0;
		end else if (rise && first_r && cnt_r == 4'h9) begin
			first_r <= 1'b0;
			rd_r    <= addr_r[0];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rise && first_r && cnt_r < 4'h8) begin
			addr_r <= {addr_r[6:0], sda};
		end
	end

	// Memory must stay off the line after a stop or a refused address
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i || stop) begin
			quiet_r <= 1'b1;
		end else if (start) begin
			quiet_r <= 1'b0;
		end else if (!scl && scl_r && first_r && cnt_r == 4'h9 && sda) begin
			quiet_r <= 1'b1;
		end
	end

	// ==========
	// Assertions
	pull_only_low_a: assert property (sda_mem_oe |-> !sda)
		else $error("memory enable set but data line high");
	mem_stable_high_a: assert property (high |-> $stable(sda_mem_oe))
		else $error("memory changed data while clock high");
	frame_boundary_a: assert property ((start || stop) && cnt_r != 4'h0 |-> cnt_r == 4'h1)
		else $error("start or stop inside a word");
	bits_no_drive_a: assert property (high && sda_mem_oe && cnt_r inside {[1:8]} |-> rd_r && !first_r)
		else $error("memory drove data outside read bits");
	read_ack_free_a: assert property (high && cnt_r == 4'h9 && rd_r && !first_r |-> !sda_mem_oe)
		else $error("memory held line during controller ack");
	addr_match_a: assert property (high && cnt_r == 4'h9 && first_r && sda_mem_oe |-> addr_r[7:3] == PREFIX)
		else $error("memory acked a foreign prefix");
	write_ack_a: assert property (high && cnt_r == 4'h9 && !first_r && !rd_r && !quiet_r |-> sda_mem_oe)
		else $error("memory missed ack of a written word");
	quiet_after_a: assert property (quiet_r |-> !sda_mem_oe)
		else $error("memory drove line while deselected");

	// ==========
	// Coverage
	cover property (start);
	cover property (high && cnt_r == 4'h9 && first_r && sda_mem_oe);
	cover property (stop && rd_r);
endmodule

// file: serial_eeprom_bus_front_end_test.sv
// Self-checking bench joining the memory front end and the controller over the link.
// Assumes both ends share the system clock; the link clock is made by the controller.
module serial_eeprom_bus_front_end_test;
	timeunit 1ns;
	timeprecision 1ps;
	import eeprom_bus_pkg::*;
	localparam logic [4:0] PFX = 5'h14;
	localparam int WR_CYC      = 600;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sel_hi = 1'b0;
	logic        sel_lo = 1'b0;
	logic        wp = 1'b0;
	logic        tx_valid = 1'b0;
	logic        rx_ready = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        cmd_start, cmd_stop, cmd_read, cmd_ack;
	word_t       tx_data = 8'h00;
	word_t       cmd_data;
	word_t       rx_data, rsp_data;
	logic        tx_ready, rx_valid, selected, read_mode, standby, busy;
	logic        cmd_ready, rsp_ack, rsp_valid;
	int          errors = 0;
	int          compares = 0;
	logic [31:0] seed = 32'hCB00;
	word_t       q[$];

	eeprom_bus_if bus();
	eeprom_front_end #(.PREFIX(PFX), .WR_LOWV(WR_CYC), .WR_STD(WR_CYC), .WR_IMPR(WR_CYC)) u_eeprom_front_end (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus(bus),
		.select_input_high_i(sel_hi), .select_input_low_i(sel_lo), .write_protect_i(wp),
		.tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
		.rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
		.selected_o(selected), .read_mode_o(read_mode), .standby_o(standby), .write_busy_o(busy));
	eeprom_controller u_eeprom_controller (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus(bus), .cmd_valid_i(cmd_valid),
		.cmd_start_i(cmd_start), .cmd_stop_i(cmd_stop), .cmd_read_i(cmd_read), .cmd_ack_i(cmd_ack),
		.cmd_recover_i(1'b0), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
		.rsp_data_o(rsp_data), .rsp_ack_o(rsp_ack), .rsp_valid_o(rsp_valid));
	eeprom_bus_assertions #(.PREFIX(PFX)) u_eeprom_bus_assertions (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_oe(bus.scl_oe), .sda_ctl_oe(bus.sda_ctl_oe),
		.sda_mem_oe(bus.sda_mem_oe), .scl(bus.scl), .sda(bus.sda));

	// ==========
	// Clock, random source, checking
	always #2 ref_clk = ~ref_clk;

	function automatic word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One word on the link, waits for its response
	task automatic word(input logic st, sp, rd, ak, input word_t d);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		{cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {st, sp, rd, ak, d};
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 8000) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	// Wait until the controller is idle again
	task automatic settle();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic conclude();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		conclude();
	end

	// ==========
	// Scenarios
	initial begin
		int    n;
		word_t d;
		{cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = 12'h000;
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		check(standby, 1'b1);
		d = rnd();
		{sel_hi, sel_lo} = d[1:0];
		// Every select pair plus one foreign prefix
		for (int i = 0; i < 5; i++) begin
			d = {(i < 4) ? PFX : PFX ^ 5'h01, i[1:0], 1'b0};
			word(1'b1, 1'b1, 1'b0, 1'b0, d);
			check(rsp_ack, d[7:3] == PFX && d[2:1] == {sel_hi, sel_lo});
		end
		// Fill the read buffer until it refuses
		n = 0;
		while (n < 12) begin
			@(negedge ref_clk);
			if (tx_ready !== 1'b1) break;
			d = rnd();
			tx_data = d;
			tx_valid = 1'b1;
			q.push_back(d);
			n++;
		end
		tx_valid = 1'b0;
		check(n, 8);
		// Sequential read drains it, last byte refused, then stop
		word(1'b1, 1'b0, 1'b0, 1'b0, {PFX, sel_hi, sel_lo, 1'b1});
		check({rsp_ack, selected, read_mode}, 3'b111);
		for (int k = 0; k < 8; k++) begin
			word(1'b0, k == 7, 1'b1, k != 7, 8'h00);
			check(rsp_data, q.pop_front());
		end
		settle();
		check({standby, tx_ready}, 2'b11);
		// Protected write with the receiver stalled
		d = {PFX, sel_hi, sel_lo, 1'b0};
		wp = 1'b1;
		rx_ready = 1'b0;
		word(1'b1, 1'b0, 1'b0, 1'b0, d);
		word(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C);
		check({rsp_ack, rx_valid}, 2'b10);
		rx_ready = 1'b1;
		settle();
		check(busy, 1'b0);
		word(1'b1, 1'b1, 1'b0, 1'b0, d);
		check(rsp_ack, 1'b1);
		// Real write, polled while the write cycle runs
		wp = 1'b0;
		rx_ready = 1'b0;
		word(1'b1, 1'b0, 1'b0, 1'b0, d);
		n = rnd();
		word(1'b0, 1'b1, 1'b0, 1'b0, n[7:0]);
		check({rsp_ack, rx_valid, rx_data}, {2'b11, n[7:0]});
		rx_ready = 1'b1;
		settle();
		check({busy, standby}, 2'b10);
		word(1'b1, 1'b1, 1'b0, 1'b0, d);
		check(rsp_ack, 1'b0);
		n = 0;
		while (busy === 1'b1 && n < 2 * WR_CYC) begin
			@(negedge ref_clk);
			n++;
		end
		check(n < WR_CYC, 1'b1);
		repeat (4) @(negedge ref_clk);
		check(standby, 1'b1);
		// Repeated start after an acknowledged address
		word(1'b1, 1'b0, 1'b0, 1'b0, d);
		word(1'b1, 1'b1, 1'b0, 1'b0, d);
		check(rsp_ack, 1'b1);
		settle();
		conclude();
	end
endmodule
